// file: design/irq_ctrl_pkg.sv
// Constants, layouts and carriers for the interrupt enable and status block
package irq_ctrl_pkg;
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFF_ENABLE = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_LIVE = 8'h08;
	localparam int BIT_GATE = 31;
	localparam int BIT_CMD = 7;
	localparam int BIT_LOC = 2;
	localparam int BIT_STSV = 1;
	localparam int BIT_RESP = 0;
	localparam int SCHEME_LSB = 3;
	localparam logic [1:0] SCHEME_LOW_LEVEL = 2'h1;
	// Compact source vector order: {cmd, loc, stsv, resp}
	localparam int SRC_N = 4;
	localparam int SRC_RESP = 0;
	localparam int SRC_STSV = 1;
	localparam int SRC_LOC = 2;
	localparam int SRC_CMD = 3;
	localparam logic GATE_RST = 1'h0;
	localparam logic [3:0] SRC_EN_RST = 4'h0;
	localparam logic [3:0] FLAGS_RST = 4'h0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [31:0] data;
		logic [3:0] strb;
	} wr_req_t;

	typedef struct packed {
		logic cmd_ready_bit;
		logic status_valid_bit;
		logic response_pending_bit;
	} if_status_t;

	typedef struct packed {
		logic locality_request;
		logic locality_grant;
		logic locality_owner;
	} loc_evt_t;

	typedef enum logic [2:0] {
		IRQ_IDLE = 3'b001,
		IRQ_ACTIVE = 3'b010,
		IRQ_REARM = 3'b100
	} irq_state_t;
endpackage

// file: design/rise_detect.sv
// Per-bit rising edge detector for synchronous status levels
`timescale 1ns/1ps
module rise_detect
	import irq_ctrl_pkg::*;
#(
	parameter int WIDTH = 3
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Levels and their rising edges
	input wire logic [WIDTH-1:0] level,
	output logic [WIDTH-1:0] rise
);
	logic [WIDTH-1:0] prev_reg;
	logic [WIDTH-1:0] prev_next;

	if (WIDTH < 1) begin : g_bad_width
		$error("rise_detect: WIDTH must be at least 1");
	end

	always_comb begin
		prev_next = level;
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			// Track the pin through reset: a level already high at release is no edge
			prev_reg <= level;
		end else begin
			prev_reg <= prev_next;
		end
	end

	genvar i;
	for (i = 0; i < WIDTH; i++) begin : g_bit
		assign rise[i] = level[i] & ~prev_reg[i];
	end
endmodule

// file: design/axil_slave.sv
// AXI4-Lite slave front end: one write and one read under way at a time
`timescale 1ns/1ps
module axil_slave
	import irq_ctrl_pkg::*;
#(
	parameter int AW = ADDR_W
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// AXI4-Lite write channels
	input wire logic [AW-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read channels
	input wire logic [AW-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Register side
	output logic wr_fire,
	output wr_req_t wr_req,
	input wire logic wr_ok,
	output logic rd_fire,
	output logic [AW-1:0] rd_addr,
	input wire logic [31:0] rd_data,
	input wire logic rd_ok
);
	logic aw_full_reg, aw_full_next, w_full_reg, w_full_next;
	logic awready_reg, awready_next, wready_reg, wready_next;
	logic bvalid_reg, bvalid_next, arready_reg, arready_next, rvalid_reg, rvalid_next;
	logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
	logic [31:0] rdata_reg, rdata_next;
	wr_req_t hold_reg, hold_next;

	// The held write request carries an address of the package width
	if (AW != ADDR_W) begin : g_bad_aw
		$error("axil_slave: AW must equal ADDR_W");
	end

	assign wr_fire = aw_full_reg & w_full_reg & ~bvalid_reg;
	assign wr_req = hold_reg;
	assign rd_fire = arvalid & arready_reg;
	assign rd_addr = araddr;

	always_comb begin
		hold_next = hold_reg;
		aw_full_next = aw_full_reg;
		w_full_next = w_full_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		if (awvalid && awready_reg) begin
			hold_next.addr = awaddr;
			aw_full_next = 1'b1;
		end
		if (wvalid && wready_reg) begin
			hold_next.data = wdata;
			hold_next.strb = wstrb;
			w_full_next = 1'b1;
		end
		if (wr_fire) begin
			aw_full_next = 1'b0;
			w_full_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = wr_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (bvalid_reg && bready) begin
			bvalid_next = 1'b0;
		end
		awready_next = ~aw_full_next & ~bvalid_next & ~wr_fire;
		wready_next = ~w_full_next & ~bvalid_next & ~wr_fire;
		rvalid_next = rvalid_reg;
		rdata_next = rdata_reg;
		rresp_next = rresp_reg;
		if (rd_fire) begin
			rvalid_next = 1'b1;
			rdata_next = rd_ok ? rd_data : 32'h0;
			rresp_next = rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_reg && rready) begin
			rvalid_next = 1'b0;
		end
		arready_next = ~rvalid_next;
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			hold_reg <= '0;
			aw_full_reg <= 1'b0;
			w_full_reg <= 1'b0;
			awready_reg <= 1'b0;
			wready_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0;
			rresp_reg <= RESP_OKAY;
		end else begin
			hold_reg <= hold_next;
			aw_full_reg <= aw_full_next;
			w_full_reg <= w_full_next;
			awready_reg <= awready_next;
			wready_reg <= wready_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			arready_reg <= arready_next;
			rvalid_reg <= rvalid_next;
			rdata_reg <= rdata_next;
			rresp_reg <= rresp_next;
		end
	end

	assign awready = awready_reg;
	assign wready = wready_reg;
	assign bvalid = bvalid_reg;
	assign bresp = bresp_reg;
	assign arready = arready_reg;
	assign rvalid = rvalid_reg;
	assign rdata = rdata_reg;
	assign rresp = rresp_reg;
endmodule

// file: design/fifo_irq_enable_status.sv
// Interrupt enable, cause flags and interrupt line of the FIFO host interface
//
// Added by the designer: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
module fifo_irq_enable_status
	import irq_ctrl_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// AXI4-Lite write channels
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read channels
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Interface status and locality events
	input wire if_status_t if_status,
	input wire loc_evt_t loc_evt,
	// Interrupt to the host platform
	output logic irq
);
	logic wr_fire, wr_ok, rd_fire, rd_ok;
	wr_req_t wr_req;
	logic [ADDR_W-1:0] rd_addr;
	logic [31:0] rd_data;
	logic [2:0] rise;
	logic gate_reg, gate_next, gate_chg_reg, gate_chg_next;
	logic [SRC_N-1:0] src_en_reg, src_en_next, flags_reg, flags_next;
	logic [SRC_N-1:0] set_vec, clr_vec;
	logic loc_wait_reg, loc_wait_next;
	logic irq_reg, irq_next;
	irq_state_t state_reg, state_next;
	logic wr_enable, wr_status, eoi, gate_wr_change, gate_busy, pending;
	logic [31:0] enable_view, status_view, live_view;

	axil_slave #(
		.AW(ADDR_W)
	) u_bus (
		.mclk(mclk),
		.rst(rst),
		.awaddr(awaddr),
		.awvalid(awvalid),
		.awready(awready),
		.wdata(wdata),
		.wstrb(wstrb),
		.wvalid(wvalid),
		.wready(wready),
		.bresp(bresp),
		.bvalid(bvalid),
		.bready(bready),
		.araddr(araddr),
		.arvalid(arvalid),
		.arready(arready),
		.rdata(rdata),
		.rresp(rresp),
		.rvalid(rvalid),
		.rready(rready),
		.wr_fire(wr_fire),
		.wr_req(wr_req),
		.wr_ok(wr_ok),
		.rd_fire(rd_fire),
		.rd_addr(rd_addr),
		.rd_data(rd_data),
		.rd_ok(rd_ok)
	);

	rise_detect #(
		.WIDTH(3)
	) u_rise (
		.mclk(mclk),
		.rst(rst),
		.level({if_status.cmd_ready_bit, if_status.status_valid_bit,
			if_status.response_pending_bit}),
		.rise(rise)
	);

	// Address decode; one register set for every locality
	// shared across localities
	always_comb begin
		wr_enable = wr_fire && (wr_req.addr == OFF_ENABLE);
		wr_status = wr_fire && (wr_req.addr == OFF_STATUS);
		wr_ok = (wr_req.addr == OFF_ENABLE) || (wr_req.addr == OFF_STATUS);
		rd_ok = (rd_addr == OFF_ENABLE) || (rd_addr == OFF_STATUS) || (rd_addr == OFF_LIVE);
		eoi = wr_status;
	end

	// Register images seen by software
	always_comb begin
		enable_view = 32'h0;
		status_view = 32'h0;
		live_view = 32'h0;
		enable_view[BIT_GATE] = gate_reg;
		enable_view[BIT_CMD] = src_en_reg[SRC_CMD];
		enable_view[BIT_LOC] = src_en_reg[SRC_LOC];
		enable_view[BIT_STSV] = src_en_reg[SRC_STSV];
		enable_view[BIT_RESP] = src_en_reg[SRC_RESP];
		enable_view[SCHEME_LSB+1:SCHEME_LSB] = SCHEME_LOW_LEVEL;
		status_view[BIT_CMD] = flags_reg[SRC_CMD];
		status_view[BIT_LOC] = flags_reg[SRC_LOC];
		status_view[BIT_STSV] = flags_reg[SRC_STSV];
		status_view[BIT_RESP] = flags_reg[SRC_RESP];
		live_view[2:0] = if_status;
		live_view[3] = loc_wait_reg;
		live_view[4] = pending;
		live_view[7:5] = state_reg;
		live_view[8] = irq_reg;
		unique case (rd_addr)
			OFF_ENABLE: rd_data = enable_view;
			OFF_STATUS: rd_data = status_view;
			default: rd_data = live_view;
		endcase
	end

	// Enable register
	always_comb begin
		gate_next = gate_reg;
		src_en_next = src_en_reg;
		gate_wr_change = 1'b0;
		if (wr_enable && wr_req.strb[0]) begin
			src_en_next[SRC_CMD] = wr_req.data[BIT_CMD];
			src_en_next[SRC_LOC] = wr_req.data[BIT_LOC];
			src_en_next[SRC_STSV] = wr_req.data[BIT_STSV];
			src_en_next[SRC_RESP] = wr_req.data[BIT_RESP];
		end
		if (wr_enable && wr_req.strb[3]) begin
			gate_next = wr_req.data[BIT_GATE];
			gate_wr_change = wr_req.data[BIT_GATE] != gate_reg;
		end
		gate_chg_next = gate_wr_change;
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			gate_reg <= GATE_RST;
			src_en_reg <= SRC_EN_RST;
			gate_chg_reg <= 1'b0;
		end else begin
			gate_reg <= gate_next;
			src_en_reg <= src_en_next;
			gate_chg_reg <= gate_chg_next;
		end
	end

	// Locality grant tracking and cause flags
	always_comb begin
		loc_wait_next = loc_wait_reg;
		set_vec = '0;
		if (loc_evt.locality_request && loc_evt.locality_owner) begin
			loc_wait_next = 1'b1;
		end
		if (loc_evt.locality_grant && loc_wait_reg) begin
			set_vec[SRC_LOC] = 1'b1;
			loc_wait_next = 1'b0;
		end
		set_vec[SRC_CMD] = rise[2];
		set_vec[SRC_STSV] = rise[1];
		set_vec[SRC_RESP] = rise[0] & if_status.status_valid_bit;
		clr_vec = '0;
		if (wr_status && wr_req.strb[0]) begin
			clr_vec[SRC_CMD] = wr_req.data[BIT_CMD];
			clr_vec[SRC_LOC] = wr_req.data[BIT_LOC];
			clr_vec[SRC_STSV] = wr_req.data[BIT_STSV];
			clr_vec[SRC_RESP] = wr_req.data[BIT_RESP];
		end
		// New event wins over a clear in the same cycle
		flags_next = (flags_reg & ~clr_vec) | set_vec;
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			flags_reg <= FLAGS_RST;
			loc_wait_reg <= 1'b0;
		end else begin
			flags_reg <= flags_next;
			loc_wait_reg <= loc_wait_next;
		end
	end

	// Interrupt sequencing
	always_comb begin
		pending = gate_reg & |(flags_reg & src_en_reg);
		gate_busy = gate_wr_change | gate_chg_reg;
		state_next = state_reg;
		irq_next = 1'b0;
		unique case (state_reg)
			IRQ_IDLE: begin
				if (pending && !gate_busy) begin
					state_next = IRQ_ACTIVE;
					irq_next = 1'b1;
				end
			end
			IRQ_ACTIVE: begin
				if (eoi) begin
					state_next = IRQ_REARM;
				end else begin
					irq_next = irq_reg & pending & ~gate_busy;
				end
			end
			IRQ_REARM: begin
				state_next = IRQ_IDLE;
			end
			default: begin
				state_next = IRQ_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			state_reg <= IRQ_IDLE;
			irq_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			irq_reg <= irq_next;
		end
	end

	assign irq = irq_reg;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	chk_reset_clears: assert property ($fell(rst) |-> !gate_reg && src_en_reg == 4'h0)
		else $error("enables not cleared by reset");
	chk_enable_fixed_bits: assert property ($rose(rvalid) && $past(rd_addr) == OFF_ENABLE
		|-> rdata[4:3] == 2'h1 && rdata[30:8] == 23'h0 && rdata[6:5] == 2'h0)
		else $error("enable register fixed or reserved bits wrong");
	chk_status_reserved: assert property ($rose(rvalid) && $past(rd_addr) == OFF_STATUS
		|-> rdata[31:8] == 24'h0 && rdata[6:3] == 4'h0)
		else $error("status reserved bits not zero");
	chk_cmd_flag_set: assert property ($rose(if_status.cmd_ready_bit) |=> flags_reg[SRC_CMD])
		else $error("command-ready rise did not set flag");
	chk_stsv_flag_set: assert property ($rose(if_status.status_valid_bit)
		|=> flags_reg[SRC_STSV])
		else $error("status-valid rise did not set flag");
	chk_resp_flag_set: assert property ($rose(if_status.response_pending_bit)
		&& if_status.status_valid_bit |=> flags_reg[SRC_RESP])
		else $error("response rise did not set flag");
	chk_resp_flag_cause: assert property ($rose(flags_reg[SRC_RESP])
		|-> $past(if_status.response_pending_bit && if_status.status_valid_bit))
		else $error("response flag set without pending and valid");
	chk_loc_delayed: assert property (loc_evt.locality_grant && loc_wait_reg
		|=> flags_reg[SRC_LOC])
		else $error("delayed grant did not set locality flag");
	chk_loc_direct: assert property ($rose(flags_reg[SRC_LOC])
		|-> $past(loc_evt.locality_grant && loc_wait_reg))
		else $error("locality flag set without delayed grant");
	chk_loc_no_arm: assert property (loc_evt.locality_request && !loc_evt.locality_owner
		&& !loc_wait_reg |=> !loc_wait_reg)
		else $error("request without owner armed locality wait");
	chk_w1c_clear: assert property (wr_status && wr_req.strb[0] && wr_req.data[BIT_STSV]
		&& !rise[1] |=> !flags_reg[SRC_STSV])
		else $error("write one did not clear flag");
	chk_w0_keep: assert property (wr_status && !wr_req.data[BIT_CMD] && flags_reg[SRC_CMD]
		|=> flags_reg[SRC_CMD])
		else $error("write zero changed flag");
	chk_src_en_write: assert property (wr_enable && wr_req.strb[0]
		|=> src_en_reg[SRC_CMD] == $past(wr_req.data[BIT_CMD]))
		else $error("source enable write lost");
	chk_gate_off_quiet: assert property (!gate_reg |-> !irq_reg)
		else $error("interrupt while gate off");
	chk_irq_cause: assert property (irq_reg |-> $past(pending))
		else $error("interrupt without enabled cause");
	chk_irq_no_repeat: assert property ($rose(irq_reg) |-> $past(state_reg == IRQ_IDLE))
		else $error("interrupt reasserted before acknowledge");
	chk_eoi_rearm: assert property (state_reg == IRQ_ACTIVE && eoi |=> !irq_reg
		##1 (state_reg == IRQ_IDLE))
		else $error("acknowledge did not rearm interrupt");
	chk_gate_quiet: assert property ($changed(gate_reg) |-> !irq_reg ##1 !irq_reg)
		else $error("interrupt active across gate change");

	// Main scenarios reached
	cov_irq_raised: cover property ($rose(irq_reg));
	cov_rearm_again: cover property (state_reg == IRQ_REARM ##2 irq_reg);
	cov_loc_delayed: cover property (loc_evt.locality_grant && loc_wait_reg);
	cov_loc_direct: cover property (loc_evt.locality_request && !loc_evt.locality_owner);
	cov_set_and_clear: cover property (wr_status && |(clr_vec & set_vec));
endmodule

// file: testbench/irq_host_model.sv
// Host platform model: watches the interrupt line and counts assertions
`timescale 1ns/1ps
module irq_host_model (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Interrupt from the device
	input wire logic irq,
	output int rise_count
);
	logic irq_last;

	// A new interrupt is a low-to-high change of the level line
	always @(posedge mclk) begin
		if (rst) begin
			irq_last <= 1'b0;
			rise_count <= 0;
		end else begin
			irq_last <= irq;
			if (irq === 1'b1 && irq_last === 1'b0)
				rise_count <= rise_count + 1;
		end
	end
endmodule

// file: testbench/fifo_irq_enable_status_tb.sv
// Self-checking bench for the interrupt enable and status block
`timescale 1ns/1ps
`define CMP(g, e) begin checks_done++; if ((g) !== (e)) begin err_total++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module fifo_irq_enable_status_tb import irq_ctrl_pkg::*;;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic [ADDR_W-1:0] awaddr = '0;
	logic awvalid = 1'b0;
	logic awready;
	logic [31:0] wdata = '0;
	logic [3:0] wstrb = '0;
	logic wvalid = 1'b0;
	logic wready;
	logic [1:0] bresp;
	logic bvalid;
	logic bready = 1'b0;
	logic [ADDR_W-1:0] araddr = '0;
	logic arvalid = 1'b0;
	logic arready;
	logic [31:0] rdata;
	logic [1:0] rresp;
	logic rvalid;
	logic rready = 1'b0;
	if_status_t if_status = '0;
	loc_evt_t loc_evt = '0;
	logic irq;
	int rise_count;
	int err_total = 0;
	int checks_done = 0;
	logic [1:0] resp;
	logic [31:0] v;

	fifo_irq_enable_status dut_u (.mclk(mclk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.if_status(if_status), .loc_evt(loc_evt), .irq(irq));
	irq_host_model host_u (.mclk(mclk), .rst(rst), .irq(irq), .rise_count(rise_count));

	initial begin
		forever #10 mclk = ~mclk;
	end

	function automatic logic [31:0] exp_en(input logic [31:0] d);
		logic [31:0] m;
		m = (32'h1 << BIT_GATE) | (32'h1 << BIT_CMD) | (32'h1 << BIT_LOC);
		m = m | (32'h1 << BIT_STSV) | (32'h1 << BIT_RESP);
		return (d & m) | (32'(SCHEME_LOW_LEVEL) << SCHEME_LSB);
	endfunction

	task automatic end_sim();
		if (err_total == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw_hit, w_hit, b_hit;
		r = 2'h3;
		@(posedge mclk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wstrb <= 4'hf;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int n = 0; n < 40; n++) begin
			@(negedge mclk);
			aw_hit = awvalid && awready;
			w_hit = wvalid && wready;
			b_hit = bvalid && bready;
			if (b_hit)
				r = bresp;
			@(posedge mclk);
			if (aw_hit)
				awvalid <= 1'b0;
			if (w_hit)
				wvalid <= 1'b0;
			if (b_hit) begin
				bready <= 1'b0;
				return;
			end
		end
		err_total++;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		logic ar_hit, r_hit;
		@(posedge mclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (int n = 0; n < 40; n++) begin
			@(negedge mclk);
			ar_hit = arvalid && arready;
			r_hit = rvalid && rready;
			if (r_hit) begin
				`CMP(rdata, e);
				`CMP(rresp, er);
			end
			@(posedge mclk);
			if (ar_hit)
				arvalid <= 1'b0;
			if (r_hit) begin
				rready <= 1'b0;
				return;
			end
		end
		err_total++;
	endtask

	task automatic wait_n(input int n);
		repeat (n) @(posedge mclk);
		@(negedge mclk);
	endtask

	task automatic irq_chk(input logic e, input int cnt);
		wait_n(4);
		`CMP(irq, e);
		`CMP(rise_count, cnt);
	endtask

	task automatic put_sts(input logic c, input logic s, input logic p);
		@(posedge mclk);
		if_status <= '{cmd_ready_bit: c, status_valid_bit: s, response_pending_bit: p};
		wait_n(3);
	endtask

	// One-cycle request or grant pulse; the owner level stays as given
	task automatic put_loc(input logic [2:0] e);
		@(posedge mclk);
		loc_evt <= e;
		@(posedge mclk);
		loc_evt <= {2'b00, e[0]};
		wait_n(2);
	endtask

	initial begin
		#400000;
		err_total++;
		end_sim();
	end

	initial begin
		void'($urandom(10));
		repeat (4) @(posedge mclk);
		rst <= 1'b0;
		rd_chk(OFF_ENABLE, 32'h8, RESP_OKAY);
		rd_chk(OFF_STATUS, 32'h0, RESP_OKAY);
		for (int i = 0; i < 8; i++) begin
			v = (i == 0) ? 32'hffffffff : $urandom;
			wr(OFF_ENABLE, v, resp);
			`CMP(resp, RESP_OKAY);
			rd_chk(OFF_ENABLE, exp_en(v), RESP_OKAY);
		end
		wr(OFF_ENABLE, 32'h0, resp);
		wr(8'h0c, 32'hffffffff, resp);
		`CMP(resp, RESP_SLVERR);
		wr(OFF_LIVE, 32'h0, resp);
		`CMP(resp, RESP_SLVERR);
		rd_chk(8'h0c, 32'h0, RESP_SLVERR);
		// Sources enabled but gate off: flags collect, line stays quiet
		wr(OFF_ENABLE, 32'h87, resp);
		put_sts(1'b1, 1'b0, 1'b0);
		rd_chk(OFF_STATUS, 32'h80, RESP_OKAY);
		put_sts(1'b1, 1'b1, 1'b0);
		rd_chk(OFF_STATUS, 32'h82, RESP_OKAY);
		put_sts(1'b1, 1'b1, 1'b1);
		rd_chk(OFF_STATUS, 32'h83, RESP_OKAY);
		irq_chk(1'b0, 0);
		wr(OFF_STATUS, 32'h3, resp);
		rd_chk(OFF_STATUS, 32'h80, RESP_OKAY);
		put_sts(1'b0, 1'b0, 1'b0);
		put_sts(1'b0, 1'b0, 1'b1);
		rd_chk(OFF_STATUS, 32'h80, RESP_OKAY);
		put_sts(1'b0, 1'b0, 1'b0);
		put_loc(3'b100);
		put_loc(3'b011);
		rd_chk(OFF_STATUS, 32'h80, RESP_OKAY);
		put_loc(3'b101);
		rd_chk(OFF_STATUS, 32'h80, RESP_OKAY);
		put_loc(3'b011);
		put_loc(3'b000);
		rd_chk(OFF_STATUS, 32'h84, RESP_OKAY);
		// Gate on with only the command source enabled
		wr(OFF_ENABLE, 32'h80000080, resp);
		irq_chk(1'b1, 1);
		wr(OFF_ENABLE, 32'h80000000, resp);
		irq_chk(1'b0, 1);
		wr(OFF_ENABLE, 32'h80000080, resp);
		irq_chk(1'b0, 1);
		wr(OFF_STATUS, 32'h0, resp);
		irq_chk(1'b1, 2);
		rd_chk(OFF_STATUS, 32'h84, RESP_OKAY);
		wr(OFF_STATUS, 32'h84, resp);
		irq_chk(1'b0, 2);
		rd_chk(OFF_STATUS, 32'h0, RESP_OKAY);
		wr(OFF_ENABLE, 32'h2, resp);
		put_sts(1'b0, 1'b1, 1'b0);
		irq_chk(1'b0, 2);
		wr(OFF_ENABLE, 32'h80000002, resp);
		irq_chk(1'b1, 3);
		wr(OFF_ENABLE, 32'h2, resp);
		irq_chk(1'b0, 3);
		// Live view: status-valid level high, sequencer still active awaiting acknowledge
		rd_chk(OFF_LIVE, 32'h42, RESP_OKAY);
		end_sim();
	end
endmodule
